/* File: core/cfr_fault_core.v */
/*
 * Controller fault response: decides input faults, display codes and
 * output overrides, with an Avalon-MM register slave and one interrupt.
 * Assumes all measurement inputs are synchronous to clk and already
 * scaled; the PID stage supplies its own heat/cool demands.
 */
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cfr_defs.vh"

module cfr_fault_core (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Avalon-MM slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         irq,
    // Measurements
    input  wire [15:0] process_value,
    input  wire [15:0] range_lo,
    input  wire [15:0] range_hi,
    input  wire        sensor_open,
    input  wire        sensor_short,
    input  wire [2:0]  rtd_line_open,
    input  wire        converter_err,
    input  wire        memory_err,
    input  wire [15:0] heater_current,
    input  wire [15:0] leak_current,
    input  wire        heater_burnout_alarm,
    input  wire        heater_short_alarm,
    input  wire [15:0] ambient_temp,
    // Normal demands from the control stages
    input  wire        heat_demand,
    input  wire        cool_demand,
    input  wire [1:0]  aux_demand,
    input  wire [1:0]  alarm_demand,
    input  wire [15:0] transfer_demand,
    input  wire [1:0]  alarm_on_high,
    // Outputs
    output reg         heat_out,
    output reg         cool_out,
    output reg  [1:0]  aux_out,
    output reg  [1:0]  alarm_out,
    output reg  [15:0] transfer_out,
    output reg  [15:0] linear_mv_out,
    output reg  [2:0]  pv_display_code,
    output reg         cur_overrange_code,
    output reg         leak_overrange_code,
    output reg         monitor_flash,
    output reg         ambient_dashes,
    output reg         input_fault
);

    // Software state
    reg [31:0] ctrl_q;
    reg [15:0] lim_lo_q;
    reg [15:0] lim_hi_q;
    reg [3:0]  assign_q;       // [1:0] aux follows fault, [2] heat, [3] cool
    reg [15:0] fault_mv_q;
    reg [`CFR_NEV-1:0] istat_q;
    reg [`CFR_NEV-1:0] imask_q;
    reg        conv_lat_q;
    reg        mem_lat_q;
    reg        in_fault_q;
    reg        rd_pend_q;

    wire [1:0]  in_type = ctrl_q[`CFR_CTL_TYPE_MSB:`CFR_CTL_TYPE_LSB];
    wire        fahr    = ctrl_q[`CFR_CTL_FAHR];
    wire        mv_en   = ctrl_q[`CFR_CTL_MV_EN];

    // Control band; 20-bit signed to avoid overflow at the extremes
    reg signed [19:0] band_lo;
    reg signed [19:0] band_hi;
    reg signed [19:0] span;
    wire signed [19:0] pv_s  = {{4{process_value[15]}}, process_value};
    wire signed [19:0] llo_s = {{4{lim_lo_q[15]}}, lim_lo_q};
    wire signed [19:0] lhi_s = {{4{lim_hi_q[15]}}, lim_hi_q};
    wire signed [19:0] margin = fahr ? {4'h0, `CFR_MARGIN_F} : {4'h0, `CFR_MARGIN_C};
    reg signed [27:0] span_x;
    always @* begin
        span    = lhi_s - llo_s;
        span_x  = 28'h0000000;
        band_lo = llo_s - margin;
        band_hi = lhi_s + margin;
        case (in_type)
            `CFR_TYPE_NONCON: begin
                band_lo = {{4{range_lo[15]}}, range_lo};
                band_hi = {{4{range_hi[15]}}, range_hi};
            end
            `CFR_TYPE_ANALOG: begin
                // Integer percent math; truncation acceptable for a margin
                span_x  = {{8{span[19]}}, span} * $signed({20'h00000, `CFR_AN_LO_PCT});
                band_lo = llo_s - span_x[19:0] / $signed({12'h000, `CFR_PCT_FULL});
                span_x  = {{8{span[19]}}, span} * $signed({20'h00000, `CFR_AN_HI_PCT});
                band_hi = llo_s + span_x[19:0] / $signed({12'h000, `CFR_PCT_FULL});
            end
            default: begin
            end
        endcase
    end

    // Open and short faults apply to every input type; line-open faults only to RTD
    wire wire_fault = sensor_open | sensor_short
                    | ((in_type == `CFR_TYPE_RTD) & (|rtd_line_open));
    wire in_fault_d = wire_fault | (pv_s < band_lo) | (pv_s > band_hi);

    // Display overflow and monitors: informative only; internal (latched converter/memory fault) forces the outputs off
    wire pv_under = $signed(process_value) < $signed(`CFR_DISP_MIN);
    wire pv_over  = $signed(process_value) > $signed(`CFR_DISP_MAX);
    wire cur_over = heater_current > `CFR_CUR_MAX;
    wire leak_over = leak_current > `CFR_CUR_MAX;
    wire [15:0] amb_lo = fahr ? `CFR_AMB_LO_F : `CFR_AMB_LO_C;
    wire [15:0] amb_hi = fahr ? `CFR_AMB_HI_F : `CFR_AMB_HI_C;
    wire amb_bad = ($signed(ambient_temp) < $signed(amb_lo))
                 | ($signed(ambient_temp) > $signed(amb_hi));
    wire heater_alm = heater_burnout_alarm | heater_short_alarm;
    wire internal = conv_lat_q | mem_lat_q;

    wire [`CFR_NEV-1:0] ev = {amb_bad, heater_alm, cur_over, memory_err, converter_err, in_fault_d};

    // Bus access; reads answer one cycle after the request
    wire wr = avs_write & ~avs_waitrequest;   // Lands only at the completing edge
    wire rd_go = avs_read & ~rd_pend_q;

    // Register file, latches and sticky status
    always @(posedge clk) begin
        if (reset) begin
            ctrl_q     <= `CFR_RST_ZERO32;
            lim_lo_q   <= `CFR_RST_LIM_LO;
            lim_hi_q   <= `CFR_RST_LIM_HI;
            assign_q   <= 4'h0;
            fault_mv_q <= `CFR_LIN_ZERO;
            istat_q    <= {`CFR_NEV{1'b0}};
            imask_q    <= {`CFR_NEV{1'b0}};
            conv_lat_q <= 1'b0;
            mem_lat_q  <= 1'b0;
            in_fault_q <= 1'b0;
            rd_pend_q  <= 1'b0;
        end else begin
            rd_pend_q  <= rd_go;
            in_fault_q <= in_fault_d;
            // Held until reset so outputs cannot chatter on a flaky fault
            if (converter_err)
                conv_lat_q <= 1'b1;
            if (memory_err)
                mem_lat_q <= 1'b1;
            if (wr) begin
                case (avs_address)
                    `CFR_A_CTRL:     ctrl_q     <= avs_writedata;
                    `CFR_A_LIM_LO:   lim_lo_q   <= avs_writedata[15:0];
                    `CFR_A_LIM_HI:   lim_hi_q   <= avs_writedata[15:0];
                    `CFR_A_ASSIGN:   assign_q   <= avs_writedata[3:0];
                    `CFR_A_FAULT_MV: fault_mv_q <= avs_writedata[15:0];
                    `CFR_A_IRQ_MASK: imask_q    <= avs_writedata[`CFR_NEV-1:0];
                    default: begin
                    end
                endcase
            end
            // Set wins over a write-one-to-clear in the same cycle
            if (wr && avs_address == `CFR_A_IRQ_STAT)
                istat_q <= (istat_q & ~avs_writedata[`CFR_NEV-1:0]) | ev;
            else
                istat_q <= istat_q | ev;
        end
    end

    // Read data and waitrequest
    always @(posedge clk) begin
        if (reset) begin
            avs_readdata    <= `CFR_RST_ZERO32;
            avs_waitrequest <= 1'b1;
            irq             <= 1'b0;
        end else begin
            irq <= |(istat_q & imask_q);
            // Writes and reads alike hold waitrequest one cycle
            avs_waitrequest <= ~((avs_write & avs_waitrequest) | rd_go);
            avs_readdata <= `CFR_RST_ZERO32;
            if (rd_go) begin
                case (avs_address)
                    `CFR_A_CTRL:     avs_readdata <= ctrl_q;
                    `CFR_A_LIM_LO:   avs_readdata <= {16'h0000, lim_lo_q};
                    `CFR_A_LIM_HI:   avs_readdata <= {16'h0000, lim_hi_q};
                    `CFR_A_ASSIGN:   avs_readdata <= {28'h0000000, assign_q};
                    `CFR_A_FAULT_MV: avs_readdata <= {16'h0000, fault_mv_q};
                    `CFR_A_STATUS:   avs_readdata <= {26'h0000000, amb_bad, heater_alm, cur_over,
                                                      mem_lat_q, conv_lat_q, in_fault_q};
                    `CFR_A_IRQ_STAT: avs_readdata <= {26'h0000000, istat_q};
                    `CFR_A_IRQ_MASK: avs_readdata <= {26'h0000000, imask_q};
                    `CFR_A_DISPLAY:  avs_readdata <= {24'h000000, ambient_dashes, monitor_flash,
                                                      leak_overrange_code, cur_overrange_code,
                                                      1'b0, pv_display_code};
                    `CFR_A_OUTPUTS:  avs_readdata <= {alarm_out, aux_out, cool_out, heat_out,
                                                      10'h000, transfer_out[15:12], 12'h000};
                    default:         avs_readdata <= `CFR_RST_ZERO32;
                endcase
            end
        end
    end

    // Output override; internal faults take priority over input faults and normal demands
    always @(posedge clk) begin
        if (reset) begin
            heat_out        <= 1'b0;
            cool_out        <= 1'b0;
            aux_out         <= 2'h0;
            alarm_out       <= 2'h0;
            transfer_out    <= `CFR_LIN_ZERO;
            linear_mv_out   <= `CFR_LIN_ZERO;
            pv_display_code <= `CFR_CODE_NONE;
            cur_overrange_code  <= 1'b0;
            leak_overrange_code <= 1'b0;
            monitor_flash   <= 1'b0;
            ambient_dashes  <= 1'b0;
            input_fault     <= 1'b0;
        end else begin
            input_fault <= in_fault_q;
            cur_overrange_code  <= cur_over;
            leak_overrange_code <= leak_over;
            monitor_flash       <= heater_alm;
            ambient_dashes      <= amb_bad;
            if (internal) begin
                heat_out      <= 1'b0;
                cool_out      <= 1'b0;
                aux_out       <= 2'h0;
                alarm_out     <= 2'h0;
                transfer_out  <= `CFR_LIN_ZERO;
                linear_mv_out <= `CFR_LIN_ZERO;
                pv_display_code <= mem_lat_q ? `CFR_CODE_MEM : `CFR_CODE_CONV;
            end else if (in_fault_q) begin
                alarm_out <= alarm_on_high;
                transfer_out <= `CFR_LIN_FULL;
                aux_out <= aux_demand | assign_q[1:0];
                // Control off unless assigned, or for heat a nonzero fault value with mv_en
                heat_out <= assign_q[2] | (mv_en & (|fault_mv_q));
                cool_out <= assign_q[3];
                linear_mv_out <= mv_en ? fault_mv_q : `CFR_LIN_ZERO;
                pv_display_code <= `CFR_CODE_INPUT;
            end else begin
                heat_out      <= heat_demand;
                cool_out      <= cool_demand;
                aux_out       <= aux_demand;
                alarm_out     <= alarm_demand;
                transfer_out  <= transfer_demand;
                linear_mv_out <= heat_demand ? `CFR_LIN_FULL : `CFR_LIN_ZERO;
                // Overflow is shown but control carries on
                if (pv_under)
                    pv_display_code <= `CFR_CODE_UNDER;
                else if (pv_over)
                    pv_display_code <= `CFR_CODE_OVER;
                else
                    pv_display_code <= `CFR_CODE_NONE;
            end
        end
    end

endmodule

/* File: shared/cfr_defs.vh */
/*
 * Constants for the controller fault response block: register map,
 * field positions, reset values, display codes and numeric limits.
 * Assumes process values are signed 16-bit integers in display units
 * (decimal point ignored), heater current in 0.1 A steps, ambient in
 * whole degrees.
 */
`ifndef CFR_DEFS_VH
`define CFR_DEFS_VH

// Register word addresses (byte address = 4 * index)
`define CFR_A_CTRL        4'h0
`define CFR_A_LIM_LO      4'h1
`define CFR_A_LIM_HI      4'h2
`define CFR_A_ASSIGN      4'h3
`define CFR_A_FAULT_MV    4'h4
`define CFR_A_STATUS      4'h5
`define CFR_A_IRQ_STAT    4'h6
`define CFR_A_IRQ_MASK    4'h7
`define CFR_A_DISPLAY     4'h8
`define CFR_A_OUTPUTS     4'h9
`define CFR_AW            4

// Control register fields
`define CFR_CTL_TYPE_LSB  0
`define CFR_CTL_TYPE_MSB  1
`define CFR_CTL_FAHR      2
`define CFR_CTL_MV_EN     3

// Input types
`define CFR_TYPE_TC       2'h0
`define CFR_TYPE_RTD      2'h1
`define CFR_TYPE_NONCON   2'h2
`define CFR_TYPE_ANALOG   2'h3

// Margins and limits
`define CFR_MARGIN_C      16'h0014
`define CFR_MARGIN_F      16'h0028
`define CFR_DISP_MIN      16'hF831
`define CFR_DISP_MAX      16'h270F
`define CFR_AN_LO_PCT     8'h05
`define CFR_AN_HI_PCT     8'h69
`define CFR_PCT_FULL      8'h64
`define CFR_CUR_MAX       16'h0226
`define CFR_AMB_LO_C      16'hFFE2
`define CFR_AMB_HI_C      16'h004B
`define CFR_AMB_LO_F      16'h000A
`define CFR_AMB_HI_F      16'h00AB

// Display codes
`define CFR_CODE_NONE     3'h0
`define CFR_CODE_INPUT    3'h1
`define CFR_CODE_UNDER    3'h2
`define CFR_CODE_OVER     3'h3
`define CFR_CODE_CONV     3'h4
`define CFR_CODE_MEM      3'h5

// Status / interrupt bit positions
`define CFR_EV_INPUT      0
`define CFR_EV_CONV       1
`define CFR_EV_MEM        2
`define CFR_EV_CUR        3
`define CFR_EV_HEATER     4
`define CFR_EV_AMB        5
`define CFR_NEV           6

// Reset values and full-scale linear output level
`define CFR_RST_LIM_LO    16'h0000
`define CFR_RST_LIM_HI    16'h0190
`define CFR_RST_ZERO32    32'h00000000
`define CFR_LIN_FULL      16'hFFFF
`define CFR_LIN_ZERO      16'h0000

`endif

/* File: dv/cfr_plant_model.sv */
/*
 * Plant model: process sensor, heater load and internal fault sources.
 * Assumes the bench calls set() just after a rising clock edge.
 */
`timescale 1ns/1ps
module cfr_plant_model (
    // Toward the fault block
    output logic [15:0] process_value,
    output logic        sensor_open,
    output logic        sensor_short,
    output logic [2:0]  rtd_line_open,
    output logic        converter_err,
    output logic        memory_err,
    output logic [15:0] heater_current,
    output logic [15:0] leak_current,
    output logic        heater_burnout_alarm,
    output logic        heater_short_alarm,
    output logic [15:0] ambient_temp
);
    // Quiet plant; 25 degrees is inside both ambient scales
    initial begin
        process_value = 16'h0064;
        {sensor_open, sensor_short, rtd_line_open, converter_err, memory_err} = 7'h00;
        heater_current = 16'h0000;
        leak_current = 16'h0000;
        {heater_burnout_alarm, heater_short_alarm} = 2'h0;
        ambient_temp = 16'h0019;
    end

    // One plant quantity changed per call
    task set(input logic [3:0] k, input logic [15:0] v);
        case (k)
            4'h0: process_value <= v;
            4'h1: sensor_open <= v[0];
            4'h2: sensor_short <= v[0];
            4'h3: rtd_line_open <= v[2:0];
            4'h4: converter_err <= v[0];
            4'h5: memory_err <= v[0];
            4'h6: heater_current <= v;
            4'h7: leak_current <= v;
            4'h8: heater_burnout_alarm <= v[0];
            4'h9: heater_short_alarm <= v[0];
            default: ambient_temp <= v;
        endcase
    endtask
endmodule

/* File: dv/cfr_fault_checker.sv */
/*
 * Checker for the fault block, bound to its top module.
 * Assumes one clock and the synchronous reset of the design.
 */
`timescale 1ns/1ps
`include "cfr_defs.vh"
module cfr_fault_checker (
    // Clock, reset and bus handshake
    input logic        clk,
    input logic        reset,
    input logic        avs_read,
    input logic        avs_waitrequest,
    // Causes
    input logic        converter_err,
    input logic        memory_err,
    input logic [15:0] heater_current,
    input logic [15:0] leak_current,
    input logic        heater_burnout_alarm,
    input logic        heater_short_alarm,
    input logic [1:0]  alarm_on_high,
    // Effects
    input logic        heat_out,
    input logic        cool_out,
    input logic [1:0]  aux_out,
    input logic [1:0]  alarm_out,
    input logic [15:0] transfer_out,
    input logic [15:0] linear_mv_out,
    input logic [2:0]  pv_display_code,
    input logic        cur_overrange_code,
    input logic        leak_overrange_code,
    input logic        monitor_flash,
    input logic        input_fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Heat, cool, aux, transfer and linear drive dark (alarm_out not included), as internal faults demand
    wire all_off = !heat_out && !cool_out && aux_out == 2'h0 && transfer_out == 16'h0000 && linear_mv_out == 16'h0000;
    wire in_shown = input_fault && pv_display_code == `CFR_CODE_INPUT;

    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
    a_read_answer: assert property ($rose(avs_read) |-> ##[1:4] !avs_waitrequest) else $error("read unanswered");
    a_conv_off:
        assert property (converter_err |-> ##2 all_off && pv_display_code >= `CFR_CODE_CONV) else $error("conv");
    a_mem_off:
        assert property (memory_err |-> ##2 (all_off && pv_display_code == `CFR_CODE_MEM)) else $error("mem fault");
    a_fault_latch:
        assert property ($fell(converter_err) |-> ##1 (pv_display_code == `CFR_CODE_CONV)[*8]) else $error("unlatched");
    a_input_alarm: assert property (in_shown |-> alarm_out == $past(alarm_on_high)) else $error("alarm");
    a_input_xfer: assert property (in_shown |-> transfer_out == `CFR_LIN_FULL) else $error("transfer");
    a_cur_over:
        assert property (1'b1 |=> cur_overrange_code == ($past(heater_current) > `CFR_CUR_MAX)) else $error("cur");
    a_leak_over:
        assert property (1'b1 |=> leak_overrange_code == ($past(leak_current) > `CFR_CUR_MAX)) else $error("leak");
    a_heater_flash:
        assert property (heater_burnout_alarm || heater_short_alarm |=> monitor_flash) else $error("no flash");
    c_conv: cover property (pv_display_code == `CFR_CODE_CONV);
    c_input: cover property (in_shown && alarm_out != 2'h0);
    c_flash: cover property (monitor_flash);
endmodule

bind cfr_fault_core cfr_fault_checker chk_u (.*);

/* File: dv/controller_fault_response_test.sv */
/*
 * Self-checking bench for the fault block: Avalon-MM tasks and a plant model.
 * Assumes the design answers each access within a few cycles.
 */
`timescale 1ns/1ps
`include "cfr_defs.vh"
module controller_fault_response_test;
    // Bench-driven inputs
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [15:0] range_lo = 16'h0000;
    logic [15:0] range_hi = 16'h03E8;
    logic [1:0]  alarm_on_high = 2'h2;
    // Plant side and design outputs
    logic [15:0] process_value, heater_current, leak_current, ambient_temp, transfer_out, linear_mv_out;
    logic [2:0]  rtd_line_open, pv_display_code;
    logic [1:0]  aux_out, alarm_out;
    logic [31:0] avs_readdata, rd_q;
    logic        sensor_open, sensor_short, converter_err, memory_err, heater_burnout_alarm, heater_short_alarm;
    logic        avs_waitrequest, irq, heat_out, cool_out, cur_overrange_code, leak_overrange_code;
    logic        monitor_flash, ambient_dashes, input_fault;
    integer      n_mismatch = 0;
    integer      check_count = 0;
    integer      i;
    // Monitor table {ctrl, plant item, value, expected cur/leak/flash/dashes}
    logic [27:0] mt [16] = '{28'h0602278, 28'h0602260, 28'h0702274, 28'h0702260, 28'h0800012, 28'h0800000,
        28'h0900012, 28'h0900000, 28'h0AFFE11, 28'h0AFFE20, 28'h0A004C1, 28'h0A004B0, 28'h4A00091,
        28'h4A000A0, 28'h4A00AC1, 28'h4A00AB0};

    always #2 clk = ~clk;

    // Control demands held steady so overrides stand out
    cfr_fault_core dut_u (.*, .heat_demand(1'b1), .cool_demand(1'b1), .aux_demand(2'h0), .alarm_demand(2'h0),
        .transfer_demand(16'h1234));
    cfr_plant_model pm_u (.*);

    task tally_and_finish;
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One access; request held until waitrequest is sampled low, then an idle edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 40) begin
            n_mismatch++;
            tally_and_finish;
        end
        @(posedge clk);
    endtask

    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk("register", rd_q, e);
    endtask

    // Three edges cover the fault register plus the output stage
    task settle;
        repeat (3) @(posedge clk);
    endtask

    task restart;
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask

    task automatic band(input logic [3:0] c, input logic [15:0] v, input logic f, input logic [2:0] code);
        bus(1'b1, `CFR_A_CTRL, {28'h0000000, c});
        pm_u.set(4'h0, v);
        settle;
        chk("input_fault", input_fault, f);
        chk("pv_display_code", pv_display_code, code);
        chk("outputs", {heat_out, cool_out, aux_out, alarm_out, transfer_out}, f ? 22'h02FFFF : 22'h301234);
    endtask

    initial begin
        restart;
        rc(`CFR_A_LIM_HI, 32'h00000190);
        rc(`CFR_A_LIM_LO, 32'h00000000);
        bus(1'b1, 4'hF, 32'hFFFFFFFF);
        rc(4'hF, 32'h00000000);
        bus(1'b1, `CFR_A_STATUS, 32'h0000003F);
        rc(`CFR_A_STATUS, 32'h00000000);
        band(4'h0, 16'h01A4, 1'b0, 3'h0);
        band(4'h0, 16'h01A5, 1'b1, 3'h1);
        band(4'h0, 16'hFFEC, 1'b0, 3'h0);
        band(4'h4, 16'h01B9, 1'b1, 3'h1);
        band(4'h4, 16'h01B8, 1'b0, 3'h0);
        band(4'h2, 16'h03E8, 1'b0, 3'h0);
        band(4'h2, 16'h03E9, 1'b1, 3'h1);
        for (int b = 0; b < 3; b++) begin
            pm_u.set(4'h3, 16'h0001 << b);
            band(4'h1, 16'h0064, 1'b1, 3'h1);
        end
        band(4'h0, 16'h0064, 1'b0, 3'h0);
        pm_u.set(4'h3, 16'h0000);
        pm_u.set(4'h2, 16'h0001);
        band(4'h1, 16'h0064, 1'b1, 3'h1);
        pm_u.set(4'h2, 16'h0000);
        pm_u.set(4'h1, 16'h0001);
        band(4'h0, 16'h0064, 1'b1, 3'h1);
        pm_u.set(4'h1, 16'h0000);
        bus(1'b1, `CFR_A_LIM_HI, 32'h000003E8);
        rc(`CFR_A_LIM_HI, 32'h000003E8);
        band(4'h3, 16'h041A, 1'b0, 3'h0);
        band(4'h3, 16'h041B, 1'b1, 3'h1);
        band(4'h3, 16'hFFCE, 1'b0, 3'h0);
        band(4'h3, 16'hFFCD, 1'b1, 3'h1);
        range_lo <= 16'hF448;
        range_hi <= 16'h2EE0;
        band(4'h2, 16'hF830, 1'b0, `CFR_CODE_UNDER);
        band(4'h2, 16'hF831, 1'b0, 3'h0);
        band(4'h2, 16'h2710, 1'b0, `CFR_CODE_OVER);
        band(4'h2, 16'h270F, 1'b0, 3'h0);
        // Overrides while an input fault stands
        bus(1'b1, `CFR_A_IRQ_MASK, 32'h00000001);
        band(4'h0, 16'hFFEB, 1'b1, 3'h1);
        chk("irq", irq, 1'b1);
        alarm_on_high <= 2'h1;
        settle;
        chk("alarm_out", alarm_out, 2'h1);
        alarm_on_high <= 2'h2;
        bus(1'b1, `CFR_A_ASSIGN, 32'h0000000F);
        settle;
        chk("assigned", {heat_out, cool_out, aux_out}, 4'hF);
        bus(1'b1, `CFR_A_ASSIGN, 32'h00000000);
        bus(1'b1, `CFR_A_FAULT_MV, 32'h00000777);
        bus(1'b1, `CFR_A_CTRL, 32'h00000008);
        settle;
        chk("linear_mv_out", linear_mv_out, 16'h0777);
        // Sticky status survives the cause; write one clears it; mask gates irq
        band(4'h0, 16'h0064, 1'b0, 3'h0);
        rc(`CFR_A_IRQ_STAT, 32'h00000001);
        chk("irq", irq, 1'b1);
        bus(1'b1, `CFR_A_IRQ_STAT, 32'h00000001);
        settle;
        chk("irq", irq, 1'b0);
        bus(1'b1, `CFR_A_IRQ_MASK, 32'h00000000);
        band(4'h0, 16'hFFEB, 1'b1, 3'h1);
        chk("irq", irq, 1'b0);
        band(4'h0, 16'h0064, 1'b0, 3'h0);
        rc(`CFR_A_IRQ_STAT, 32'h00000001);
        for (int m = 0; m < 16; m++) begin
            bus(1'b1, `CFR_A_CTRL, {28'h0000000, mt[m][27:24]});
            pm_u.set(mt[m][23:20], mt[m][19:4]);
            settle;
            chk("monitors", {cur_overrange_code, leak_overrange_code, monitor_flash, ambient_dashes}, mt[m][3:0]);
        end
        // Internal faults: latched through the cause going away, cleared by reset
        for (int k = 4; k < 6; k++) begin
            pm_u.set(k[3:0], 16'h0001);
            settle;
            chk("internal code", pv_display_code, k == 4 ? `CFR_CODE_CONV : `CFR_CODE_MEM);
            chk("outputs off", {heat_out, cool_out, aux_out, transfer_out, linear_mv_out}, 36'h0);
            pm_u.set(k[3:0], 16'h0000);
            repeat (4) settle;
            chk("latched code", pv_display_code, k == 4 ? `CFR_CODE_CONV : `CFR_CODE_MEM);
            restart;
            settle;
            chk("cleared code", pv_display_code, `CFR_CODE_NONE);
        end
        tally_and_finish;
    end
endmodule
